// >>> verilog/ptimer_pkg.sv
/*
 * Constants for the paired 16/32-bit timer: register indexes, control
 * field positions, reset values and prescale ratios.
 * Assumes a 20 MHz instruction clock and a simple strobe register port.
 */
package ptimer_pkg;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;

    // Register indexes on the plain register port
    localparam logic [3:0] REG_LOW_CTRL    = 4'h0;
    localparam logic [3:0] REG_HIGH_CTRL   = 4'h1;
    localparam logic [3:0] REG_COUNT_LOW   = 4'h2;
    localparam logic [3:0] REG_COUNT_HIGH  = 4'h3;
    localparam logic [3:0] REG_PERIOD_LOW  = 4'h4;
    localparam logic [3:0] REG_PERIOD_HIGH = 4'h5;
    localparam logic [3:0] REG_IRQ_FLAGS   = 4'h6;
    localparam logic [3:0] REG_IRQ_ENABLE  = 4'h7;

    // Control register field positions
    localparam int unsigned RUN_BIT      = 15;
    localparam int unsigned IDLE_BIT     = 13;
    localparam int unsigned GATE_BIT     = 6;
    localparam int unsigned PRESCALE_HI  = 5;
    localparam int unsigned PRESCALE_LO  = 4;
    localparam int unsigned WIDE_BIT     = 3;
    localparam int unsigned CLKSRC_BIT   = 1;

    // Implemented control bits; low control has the wide bit, high does not
    localparam logic [15:0] LOW_CTRL_MASK  = 16'ha07a;
    localparam logic [15:0] HIGH_CTRL_MASK = 16'ha072;
    localparam logic [15:0] CTRL_RESET     = 16'h0000;
    localparam logic [15:0] PERIOD_RESET   = 16'hffff;

    // Flag bit positions in the flag and enable registers
    localparam int unsigned FLAG_LOW  = 0;
    localparam int unsigned FLAG_HIGH = 1;

    // Prescale ratios less one, indexed by the prescale field
    localparam logic [7:0] PRE_DIV1   = 8'h00;
    localparam logic [7:0] PRE_DIV8   = 8'h07;
    localparam logic [7:0] PRE_DIV64  = 8'h3f;
    localparam logic [7:0] PRE_DIV256 = 8'hff;

endpackage

// >>> verilog/ptimer_tick.sv
/*
 * One timer's clock selection, gating and prescaler. Emits a one-cycle
 * count enable per prescaled input event.
 * Assumes the external count input is already synchronous to mclk.
 */
module ptimer_tick
    import ptimer_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       run,
    input  wire logic       clk_src,
    input  wire logic       gate_en,
    input  wire logic [1:0] prescale,
    input  wire logic       ext_in,
    input  wire logic       gate_in,
    output logic            tick
);

    typedef struct packed {
        logic [7:0] pre;
        logic       ext_d;
        logic       tick;
    } tick_state_t;

    tick_state_t s_r;
    tick_state_t s_nxt;
    logic        event_in;
    logic [7:0]  limit;

    always_comb
    begin
        s_nxt       = s_r;
        s_nxt.ext_d = ext_in;
        s_nxt.tick  = 1'b0;
        case (prescale)
            2'b00:   limit = PRE_DIV1;
            2'b01:   limit = PRE_DIV8;
            2'b10:   limit = PRE_DIV64;
            default: limit = PRE_DIV256;
        endcase
        // Gating only means something on the internal clock
        if (clk_src)
            event_in = ext_in && !s_r.ext_d;
        else if (gate_en)
            event_in = gate_in;
        else
            event_in = 1'b1;
        if (!run)
            s_nxt.pre = 8'h00;
        else if (event_in)
        begin
            if (s_r.pre >= limit)
            begin
                s_nxt.pre  = 8'h00;
                s_nxt.tick = 1'b1;
            end
            else
                s_nxt.pre = s_r.pre + 8'h01;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign tick = s_r.tick;

    tick_rate_a: assert property (@(posedge mclk) disable iff (!rstn)
        (run && !clk_src && !gate_en && prescale == 2'b00 && $past(run)
         && $past(run, 2) && $past(prescale) == 2'b00 && !$past(clk_src)
         && !$past(gate_en)) |-> ##1 tick)
        else $error("Divide by one tick missing");

endmodule

// >>> verilog/ptimer.sv
/*
 * Paired 16-bit timers, cascadable into one 32-bit timer or counter.
 * Registers on a plain strobe port with read data one cycle later.
 * Assumes inputs synchronous to mclk; interrupt priority lives elsewhere.
 */
// The implementer's own choices: the strobed register port and the address map.
// Overview of operation
// - Wide bit joins timers into 32 bits
// - Low timer is low word, high upper
// - In wide mode high control is ignored
// - Wide uses low clock/gate, high flag
// - Wide period is period_high:period_low
// - Count pair reads running 32-bit count
// - Interrupt on 32-bit count/period match
// - Prescale divides by 1, 8, 64, 256
// - Gating only with internal clock
// - Split timers: all modes but asynchronous
// - Pair works as synchronous 32-bit counter
// - Timers run in sleep; idle bit halts in idle
// - Only 32-bit timer triggers the converter
// - Unimplemented bits read zero; reset clears, but periods reset to ffff
module ptimer
    import ptimer_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rstn,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [DATA_W-1:0] rdata,
    input  wire logic              ext_count_low,
    input  wire logic              ext_count_high,
    input  wire logic              gate_low,
    input  wire logic              gate_high,
    input  wire logic              idle_mode,
    output logic                   match_low,
    output logic                   match_high,
    output logic                   adc_trigger
);

    typedef struct packed {
        logic [15:0] low_ctrl;
        logic [15:0] high_ctrl;
        logic [15:0] count_low;
        logic [15:0] count_high;
        logic [15:0] period_low;
        logic [15:0] period_high;
        logic [1:0]  flags;
        logic [1:0]  irq_en;
        logic [15:0] rdata;
        logic        match_low;
        logic        match_high;
        logic        adc_trig;
        logic        irq_low;
        logic        irq_high;
    } timer_state_t;

    timer_state_t s_r;
    timer_state_t s_nxt;

    logic        wide;
    logic        run_low;
    logic        run_high;
    logic        tick_low;
    logic        tick_high;
    logic [31:0] count32;
    logic [31:0] period32;

    ////////////////////////////////////////////////////////////////////////
    // Mode decode

    assign wide = s_r.low_ctrl[WIDE_BIT];
    // Idle halt only applies in idle; sleep never stops a synchronous count
    assign run_low = s_r.low_ctrl[RUN_BIT]
        && !(idle_mode && s_r.low_ctrl[IDLE_BIT]);
    // High control is ignored when the pair is cascaded
    assign run_high = !wide && s_r.high_ctrl[RUN_BIT]
        && !(idle_mode && s_r.high_ctrl[IDLE_BIT]);
    assign count32  = {s_r.count_high, s_r.count_low};
    assign period32 = {s_r.period_high, s_r.period_low};

    ////////////////////////////////////////////////////////////////////////
    // Tick generators; the low one drives the pair in wide mode

    ptimer_tick u_tick_low (
        .mclk     (mclk),
        .rstn     (rstn),
        .run      (run_low),
        .clk_src  (s_r.low_ctrl[CLKSRC_BIT]),
        .gate_en  (s_r.low_ctrl[GATE_BIT]),
        .prescale (s_r.low_ctrl[PRESCALE_HI:PRESCALE_LO]),
        .ext_in   (ext_count_low),
        .gate_in  (gate_low),
        .tick     (tick_low)
    );

    ptimer_tick u_tick_high (
        .mclk     (mclk),
        .rstn     (rstn),
        .run      (run_high),
        .clk_src  (s_r.high_ctrl[CLKSRC_BIT]),
        .gate_en  (s_r.high_ctrl[GATE_BIT]),
        .prescale (s_r.high_ctrl[PRESCALE_HI:PRESCALE_LO]),
        .ext_in   (ext_count_high),
        .gate_in  (gate_high),
        .tick     (tick_high)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        s_nxt            = s_r;
        s_nxt.match_low  = 1'b0;
        s_nxt.match_high = 1'b0;
        s_nxt.adc_trig   = 1'b0;
        s_nxt.rdata      = '0;

        // Counting first so that a software write in the same cycle wins
        if (wide)
        begin
            if (tick_low && run_low)
            begin
                if (count32 == period32)
                begin
                    {s_nxt.count_high, s_nxt.count_low} = 32'h0000_0000;
                    s_nxt.match_high = 1'b1;
                    s_nxt.adc_trig   = 1'b1;
                end
                else
                    {s_nxt.count_high, s_nxt.count_low} = count32 + 32'h0000_0001;
            end
        end
        else
        begin
            if (tick_low && run_low)
            begin
                if (s_r.count_low == s_r.period_low)
                begin
                    s_nxt.count_low = 16'h0000;
                    s_nxt.match_low = 1'b1;
                end
                else
                    s_nxt.count_low = s_r.count_low + 16'h0001;
            end
            if (tick_high && run_high)
            begin
                if (s_r.count_high == s_r.period_high)
                begin
                    s_nxt.count_high = 16'h0000;
                    s_nxt.match_high = 1'b1;
                end
                else
                    s_nxt.count_high = s_r.count_high + 16'h0001;
            end
        end

        // Register writes
        if (wr)
        begin
            if (addr == REG_LOW_CTRL)
                s_nxt.low_ctrl = wdata & LOW_CTRL_MASK;
            else if (addr == REG_HIGH_CTRL)
                s_nxt.high_ctrl = wdata & HIGH_CTRL_MASK;
            else if (addr == REG_COUNT_LOW)
                s_nxt.count_low = wdata;
            else if (addr == REG_COUNT_HIGH)
                s_nxt.count_high = wdata;
            else if (addr == REG_PERIOD_LOW)
                s_nxt.period_low = wdata;
            else if (addr == REG_PERIOD_HIGH)
                s_nxt.period_high = wdata;
            else if (addr == REG_IRQ_FLAGS)
                s_nxt.flags = s_r.flags & ~wdata[1:0];
            else if (addr == REG_IRQ_ENABLE)
                s_nxt.irq_en = wdata[1:0];
        end

        // A match in the clearing cycle keeps its flag
        if (s_nxt.match_low)
            s_nxt.flags[FLAG_LOW] = 1'b1;
        if (s_nxt.match_high)
            s_nxt.flags[FLAG_HIGH] = 1'b1;

        // Enable gating is done before the flop so the outputs leave registers
        s_nxt.irq_low  = s_nxt.match_low && s_nxt.irq_en[FLAG_LOW];
        s_nxt.irq_high = s_nxt.match_high && s_nxt.irq_en[FLAG_HIGH];

        // Register reads
        if (rd)
        begin
            if (addr == REG_LOW_CTRL)
                s_nxt.rdata = s_r.low_ctrl;
            else if (addr == REG_HIGH_CTRL)
                s_nxt.rdata = s_r.high_ctrl;
            else if (addr == REG_COUNT_LOW)
                s_nxt.rdata = s_r.count_low;
            else if (addr == REG_COUNT_HIGH)
                s_nxt.rdata = s_r.count_high;
            else if (addr == REG_PERIOD_LOW)
                s_nxt.rdata = s_r.period_low;
            else if (addr == REG_PERIOD_HIGH)
                s_nxt.rdata = s_r.period_high;
            else if (addr == REG_IRQ_FLAGS)
                s_nxt.rdata = {14'h0000, s_r.flags};
            else if (addr == REG_IRQ_ENABLE)
                s_nxt.rdata = {14'h0000, s_r.irq_en};
            else
                s_nxt.rdata = 16'h0000;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_r             <= '0;
            s_r.low_ctrl    <= CTRL_RESET;
            s_r.high_ctrl   <= CTRL_RESET;
            s_r.period_low  <= PERIOD_RESET;
            s_r.period_high <= PERIOD_RESET;
        end
        else
            s_r <= s_nxt;
    end

    // Match pulses reach the interrupt controller only when enabled
    assign rdata       = s_r.rdata;
    assign match_low   = s_r.irq_low;
    assign match_high  = s_r.irq_high;
    assign adc_trigger = s_r.adc_trig;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    wide_match_a: assert property (@(posedge mclk) disable iff (!rstn)
        (wide && tick_low && run_low && count32 == period32 && !wr)
        |=> (count32 == 32'h0 && s_r.match_high && s_r.flags[FLAG_HIGH]))
        else $error("Wide match did not reload and flag");

    wide_carry_a: assert property (@(posedge mclk) disable iff (!rstn)
        (wide && tick_low && run_low && count32 != period32 && !wr)
        |=> count32 == $past(count32) + 32'h1)
        else $error("Wide count did not carry");

    // A tick already in flight when wide is set is harmless, so skip that cycle
    high_ignored_a: assert property (@(posedge mclk) disable iff (!rstn)
        (wide && $past(wide)) |-> !tick_high)
        else $error("High timer ran in wide mode");

    no_low_flag_a: assert property (@(posedge mclk) disable iff (!rstn)
        (wide && $past(wide)) |-> !s_r.match_low)
        else $error("Low flag raised in wide mode");

    irq_out_a: assert property (@(posedge mclk) disable iff (!rstn)
        match_high |-> (s_r.match_high && s_r.irq_en[FLAG_HIGH]))
        else $error("High interrupt pulse without enabled match");

    adc_wide_a: assert property (@(posedge mclk) disable iff (!rstn)
        s_r.adc_trig |-> $past(wide))
        else $error("Converter trigger outside wide mode");

    stop_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
        (!run_low && !wr) |=> s_r.count_low == $past(s_r.count_low))
        else $error("Stopped low timer changed");

    ctrl_zero_a: assert property (@(posedge mclk) disable iff (!rstn)
        (s_r.low_ctrl & ~LOW_CTRL_MASK) == 16'h0)
        else $error("Unimplemented control bit set");

    split_match_a: assert property (@(posedge mclk) disable iff (!rstn)
        (!wide && tick_low && run_low && s_r.count_low == s_r.period_low
         && !wr) |=> (s_r.count_low == 16'h0 && s_r.flags[FLAG_LOW]))
        else $error("Split match did not reload");

    split_high_a: assert property (@(posedge mclk) disable iff (!rstn)
        (!wide && tick_high && run_high && s_r.count_high == s_r.period_high
         && !wr) |=> (s_r.count_high == 16'h0 && s_r.flags[FLAG_HIGH]))
        else $error("Split high match did not reload");

    flag_sticky_a: assert property (@(posedge mclk) disable iff (!rstn)
        (s_r.flags[FLAG_HIGH] && !(wr && addr == REG_IRQ_FLAGS))
        |=> s_r.flags[FLAG_HIGH])
        else $error("High flag dropped without a clear");

    read_data_a: assert property (@(posedge mclk) disable iff (!rstn)
        (rd && addr == REG_PERIOD_HIGH) |=> rdata == $past(s_r.period_high))
        else $error("Period read wrong");

    wide_match_c: cover property (@(posedge mclk) disable iff (!rstn)
        s_r.adc_trig);
    split_match_c: cover property (@(posedge mclk) disable iff (!rstn)
        s_r.match_low && !wide);
    clear_race_c: cover property (@(posedge mclk) disable iff (!rstn)
        wr && addr == REG_IRQ_FLAGS && s_nxt.match_high);
    high_ext_c: cover property (@(posedge mclk) disable iff (!rstn)
        s_r.high_ctrl[CLKSRC_BIT] && tick_high && run_high);

endmodule

// >>> tb/tb_top.sv
/*
 * Self-checking bench for the paired timer: register reset values, control
 * masking, prescale ratios, clock source, gating, idle halt and wide mode.
 * Assumes the strobe register port with read data one cycle after the strobe.
 */
module tb_top
    import ptimer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] RUN  = 16'h8000;
    localparam logic [15:0] IDLE = 16'h2000;
    localparam logic [15:0] GATE = 16'h0040;
    localparam logic [15:0] WIDE = 16'h0008;
    localparam logic [15:0] CSRC = 16'h0002;

    logic              mclk;
    logic              rstn;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              wr;
    logic              rd;
    logic              ext_count_low;
    logic              ext_count_high;
    logic              gate_low;
    logic              idle_mode;
    logic              match_low;
    logic              match_high;
    logic              adc_trigger;
    logic [15:0]       v;
    int                fails = 0;
    int                n_compared = 0;
    int                cyc = 0;
    int                n_adc = 0;
    int                n_ml = 0;
    int                n_mh = 0;
    int                n;
    int                a0;
    int                l0;
    int                div [4] = '{1, 8, 64, 256};

    ptimer dut_u (
        .mclk           (mclk),
        .rstn           (rstn),
        .addr           (addr),
        .wdata          (wdata),
        .wr             (wr),
        .rd             (rd),
        .rdata          (rdata),
        .ext_count_low  (ext_count_low),
        .ext_count_high (ext_count_high),
        .gate_low       (gate_low),
        .gate_high      (gate_low),
        .idle_mode      (idle_mode),
        .match_low      (match_low),
        .match_high     (match_high),
        .adc_trigger    (adc_trigger)
    );

    always #25 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////
    // Pulse counters and hang guard; the run needs under two thousand cycles
    // Sampled mid-cycle, away from the edge that launches each pulse
    always @(negedge mclk)
    begin
        cyc = cyc + 1;
        if (adc_trigger === 1'b1) n_adc++;
        if (match_low === 1'b1) n_ml++;
        if (match_high === 1'b1) n_mh++;
        if (cyc == 20000)
        begin
            fails++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic rchk(input logic [3:0] a, input logic [15:0] exp, input string what);
        logic [15:0] d;
        rd_reg(a, d);
        chk(d, exp, what);
    endtask

    // Bounded wait; returns the cycles spent until the chosen match pulse
    task automatic wait_match(input bit hi, output int k);
        k = 0;
        do
        begin
            @(posedge mclk);
            #1;
            k++;
        end while (((hi ? match_high : match_low) !== 1'b1) && k < 1000);
    endtask

    // Runs one timer for a fixed span while both external pins give 5 rising edges
    task automatic run_for(input bit hi, input logic [15:0] c, output logic [15:0] d);
        wr_reg(hi ? REG_COUNT_HIGH : REG_COUNT_LOW, 16'h0000);
        wr_reg(hi ? REG_HIGH_CTRL : REG_LOW_CTRL, c);
        repeat (5)
        begin
            @(posedge mclk);
            ext_count_low  <= 1'b1;
            ext_count_high <= 1'b1;
            repeat (2) @(posedge mclk);
            ext_count_low  <= 1'b0;
            ext_count_high <= 1'b0;
            @(posedge mclk);
        end
        repeat (3) @(posedge mclk);
        wr_reg(hi ? REG_HIGH_CTRL : REG_LOW_CTRL, 16'h0000);
        rd_reg(hi ? REG_COUNT_HIGH : REG_COUNT_LOW, d);
    endtask

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        mclk = 1'b0;
        rstn = 1'b0;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        ext_count_low = 1'b0;
        ext_count_high = 1'b0;
        gate_low = 1'b0;
        idle_mode = 1'b0;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;

        rchk(REG_LOW_CTRL, CTRL_RESET, "low ctrl reset");
        rchk(REG_HIGH_CTRL, CTRL_RESET, "high ctrl reset");
        rchk(REG_PERIOD_LOW, PERIOD_RESET, "period low reset");
        rchk(REG_COUNT_HIGH, 16'h0000, "count high reset");
        wr_reg(4'h9, 16'h1234);
        rchk(4'h9, 16'h0000, "unmapped read");
        rchk(REG_PERIOD_HIGH, PERIOD_RESET, "unmapped write leaked");
        wr_reg(REG_LOW_CTRL, 16'h7fff);
        wr_reg(REG_HIGH_CTRL, 16'h7fff);
        rchk(REG_LOW_CTRL, 16'h207a, "low ctrl mask");
        rchk(REG_HIGH_CTRL, 16'h2072, "high ctrl mask");
        wr_reg(REG_LOW_CTRL, 16'h0000);
        wr_reg(REG_HIGH_CTRL, 16'h0000);
        $display("test registers done");

        // Period 1 gives a match every two prescaled ticks
        wr_reg(REG_IRQ_ENABLE, 16'h0003);
        wr_reg(REG_PERIOD_LOW, 16'h0001);
        for (int p = 0; p < 4; p++)
        begin
            wr_reg(REG_LOW_CTRL, RUN | 16'(p << 4));
            wait_match(1'b0, n);
            wait_match(1'b0, n);
            chk(16'(n), 16'(2 * div[p]), "low match interval");
            wr_reg(REG_LOW_CTRL, 16'h0000);
            wr_reg(REG_COUNT_LOW, 16'h0000);
        end
        rchk(REG_IRQ_FLAGS, 16'h0001, "low flag only");
        wr_reg(REG_PERIOD_HIGH, 16'h0001);
        wr_reg(REG_HIGH_CTRL, RUN);
        wait_match(1'b1, n);
        wait_match(1'b1, n);
        chk(16'(n), 16'h0002, "split high interval");
        wr_reg(REG_HIGH_CTRL, 16'h0000);
        chk(16'(n_adc), 16'h0000, "trigger from 16-bit timer");
        wr_reg(REG_IRQ_FLAGS, 16'h0003);
        rchk(REG_IRQ_FLAGS, 16'h0000, "flags cleared");
        $display("test prescale done");

        wr_reg(REG_PERIOD_LOW, 16'hffff);
        wr_reg(REG_PERIOD_HIGH, 16'hffff);
        run_for(1'b0, RUN | CSRC | GATE, v);
        chk(v, 16'h0005, "external edges, gate ignored");
        run_for(1'b0, RUN | GATE, v);
        chk(v, 16'h0000, "gated off");
        run_for(1'b1, RUN | CSRC, v);
        chk(v, 16'h0005, "high external edges");
        run_for(1'b1, RUN | GATE, v);
        chk(v, 16'h0000, "high gated off");
        @(posedge mclk) gate_low <= 1'b1;
        run_for(1'b0, RUN | GATE, v);
        chk({15'h0, v != 16'h0000}, 16'h0001, "gated on");
        run_for(1'b1, RUN | GATE, v);
        chk({15'h0, v != 16'h0000}, 16'h0001, "high gated on");
        @(posedge mclk) idle_mode <= 1'b1;
        run_for(1'b0, RUN | IDLE, v);
        chk(v, 16'h0000, "idle halt");
        run_for(1'b0, RUN, v);
        chk({15'h0, v != 16'h0000}, 16'h0001, "runs in idle");
        @(posedge mclk) idle_mode <= 1'b0;
        $display("test clocking done");

        // Wide mode: high control holds a slow prescale that must be ignored
        wr_reg(REG_LOW_CTRL, WIDE);
        wr_reg(REG_HIGH_CTRL, RUN | 16'h0030);
        wr_reg(REG_PERIOD_LOW, 16'h0005);
        wr_reg(REG_PERIOD_HIGH, 16'h0001);
        wr_reg(REG_COUNT_LOW, 16'hfffe);
        wr_reg(REG_COUNT_HIGH, 16'h0000);
        rchk(REG_COUNT_LOW, 16'hfffe, "count low preset");
        a0 = n_adc;
        l0 = n_ml;
        wr_reg(REG_LOW_CTRL, RUN | WIDE);
        wait_match(1'b1, n);
        chk({15'h0, n >= 7 && n <= 14}, 16'h0001, "wide match time");
        wr_reg(REG_LOW_CTRL, WIDE);
        rchk(REG_COUNT_HIGH, 16'h0000, "reload after match");
        rchk(REG_IRQ_FLAGS, 16'h0002, "high flag in wide");
        chk(16'(n_adc - a0), 16'h0001, "wide trigger");
        chk(16'(n_ml - l0), 16'h0000, "no low match in wide");
        $display("test wide done");
        wrap_up();
    end

endmodule
